/* File: mfp_pkg.sv */
package mfp_pkg;

  // ----------------------------------------
  // Register word addresses
  // ----------------------------------------
  localparam logic [15:0] ADR_CHK_CTL = 16'h1F50;
  localparam logic [15:0] ADR_BUS_CTL = 16'h1F51;
  localparam logic [15:0] ADR_BLK_ONE = 16'h1F55;
  localparam logic [15:0] ADR_BLK_TWO = 16'h1F56;
  localparam logic [15:0] ADR_OUT_LIM = 16'h1F57;
  localparam logic [15:0] ADR_IN_LIM  = 16'h1F58;
  localparam logic [15:0] ADR_FLT_ADR = 16'h1F59;
  localparam logic [15:0] ADR_FLT_DAT = 16'h1F5B;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] RST_CHK_CTL = 16'h00C6;
  localparam logic [15:0] RST_BUS_CTL = 16'hC3FF;
  localparam logic [15:0] RST_ZERO    = 16'h0000;

  // ----------------------------------------
  // Field positions (bit 15 is the first bit)
  // ----------------------------------------
  localparam int unsigned B_Q0   = 15;
  localparam int unsigned B_ODD  = 11;
  localparam int unsigned B_EEI  = 10;
  localparam int unsigned B_EED  = 9;
  localparam int unsigned B_EPR  = 8;
  localparam int unsigned B_SPD  = 7;
  localparam int unsigned B_WPT  = 6;
  localparam int unsigned B_EB1  = 5;
  localparam int unsigned B_EB2  = 4;
  localparam int unsigned B_EIO  = 3;
  localparam int unsigned B_GPT  = 2;
  localparam int unsigned B_DMX  = 1;
  localparam int unsigned B_DLP  = 0;
  localparam int unsigned B_WALO = 15;
  localparam int unsigned B_WAHI = 14;
  localparam int unsigned B_SPI  = 13;
  localparam int unsigned B_PEG  = 11;
  localparam int unsigned B_IDL  = 10;
  localparam int unsigned LIM_HI = 9;

  // ----------------------------------------
  // I/O command space
  // ----------------------------------------
  localparam logic [15:0] IO_GPT_CLR   = 16'h4003;
  localparam logic [2:0]  IO_RSV_TAG   = 3'h7;
  localparam logic [2:0]  IO_SPARE_TAG = 3'h6;
  localparam logic [4:0]  IO_SEQ_TAG   = 5'h00;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic {RDY_IDLE = 1'b0, RDY_WAIT = 1'b1} mfp_rdy_e;

  typedef struct packed {
    logic [15:0] chk_ctl;
    logic [15:0] bus_ctl;
    logic [15:0] blk_one;
    logic [15:0] blk_two;
    logic [15:0] out_lim;
    logic [15:0] in_lim;
    logic [15:0] flt_adr;
    logic [15:0] flt_dat;
    logic        flt_held;
    logic [15:0] rdata;
    logic        edac_en;
    logic        parity_en;
    logic        unused_mem;
    logic        illegal_io;
    logic        wp_pin;
    logic        ext_ready;
    logic        req_seen;
    logic        bus_grant;
    logic        ready_a;
    mfp_rdy_e    rdy_state;
    logic [1:0]  wait_cnt;
    logic [7:0]  page_out;
    logic        page_oe;
  } mfp_state_s;

  localparam mfp_state_s ST_RESET = '{
    chk_ctl: RST_CHK_CTL, bus_ctl: RST_BUS_CTL,
    blk_one: RST_ZERO, blk_two: RST_ZERO,
    out_lim: RST_ZERO, in_lim: RST_ZERO,
    flt_adr: RST_ZERO, flt_dat: RST_ZERO,
    flt_held: 1'b0, rdata: RST_ZERO,
    edac_en: 1'b0, parity_en: 1'b0, unused_mem: 1'b0,
    illegal_io: 1'b0, wp_pin: 1'b0, ext_ready: 1'b1,
    req_seen: 1'b0, bus_grant: 1'b0, ready_a: 1'b0,
    rdy_state: RDY_IDLE, wait_cnt: 2'h0,
    page_out: 8'h00, page_oe: 1'b1};

endpackage

/* File: mfp_top.sv */
// Implementation choice: the strobed register port.
`timescale 1ns/100ps
module mfp_top
(
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_b,
  // Register port
  input  wire logic [15:0] i_reg_addr,
  input  wire logic [15:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic      [15:0] o_reg_rdata,
  // Memory access
  input  wire logic        i_acc_valid,
  input  wire logic [19:0] i_acc_addr,
  input  wire logic        i_acc_fetch,
  input  wire logic        i_acc_write,
  input  wire logic        i_mem_error,
  input  wire logic [15:0] i_error_bits,
  input  wire logic        i_prot_violation,
  output logic             o_edac_en,
  output logic             o_parity_en,
  output logic             o_parity_odd,
  output logic             o_checkbit_gen_select,
  output logic             o_unused_mem,
  output logic             o_write_protect_pin,
  output logic             o_global_protect_flag,
  // Programmed I/O
  input  wire logic        i_io_valid,
  input  wire logic [15:0] i_io_cmd,
  output logic             o_illegal_io,
  // DMA and page lines
  input  wire logic        i_dma_ack,
  input  wire logic [7:0]  i_cpu_page,
  input  wire logic [7:0]  i_page_select_lines,
  output logic      [7:0]  o_page_select_lines,
  output logic             o_page_select_oe,
  output logic             o_dma_split_bus_sel,
  output logic             o_dma_address_kind,
  // Ready and arbitration
  input  wire logic        i_cache_miss,
  input  wire logic        i_ready_a_start,
  input  wire logic        i_bus_req,
  input  wire logic        i_bus_read,
  output logic             o_ext_ready,
  output logic             o_first_ready_source,
  output logic             o_bus_grant,
  output logic             o_bus_turnaround_idle_en
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------

  // Page inside an enabled block, bounds inclusive
  function automatic logic in_block
  (
    input logic [15:0] bounds,
    input logic        en,
    input logic [7:0]  page
  );
    in_block = en && (page >= bounds[15:8]) && (page <= bounds[7:0]);
  endfunction

  // Sequential command at or past the limit
  function automatic logic past_limit
  (
    input logic [15:0] cmd,
    input logic [15:0] lim
  );
    past_limit = (cmd[14:10] == mfp_pkg::IO_SEQ_TAG)
      && (cmd[mfp_pkg::LIM_HI:0] >= lim[mfp_pkg::LIM_HI:0]);
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  mfp_pkg::mfp_state_s st;
  mfp_pkg::mfp_state_s next_st;

  // Named views of the control bits
  logic       quarter_zero_check_en;
  logic       quarter_one_check_en;
  logic       quarter_two_check_en;
  logic       quarter_three_check_en;
  logic       fetch_correction_en;
  logic       operand_correction_en;
  logic       parity_check_en;
  logic       cache_miss_wait_en;
  logic       protect_pin_mode;
  logic       unused_block_one_en;
  logic       unused_block_two_en;
  logic       illegal_io_check_en;
  logic       global_protect_flag;
  logic       dma_split_bus_sel;
  logic       dma_address_kind;
  logic       ready_wait_bit_lo;
  logic       ready_wait_bit_hi;
  logic       spare_io_check_en;
  logic       checkbit_gen_select;
  logic       bus_turnaround_idle_en;

  // Access decode
  logic [3:0] quarter_en;
  logic       phys_dma;
  logic [7:0] acc_page;
  logic       quarter_hit;
  logic       edac_hit;
  logic       io_is_input;
  logic       io_bad;
  logic       rd_flt_dat;
  logic       capture;

  // Control fields out of the two control registers
  always_comb
  begin
    quarter_zero_check_en  = st.chk_ctl[mfp_pkg::B_Q0];
    quarter_one_check_en   = st.chk_ctl[mfp_pkg::B_Q0 - 1];
    quarter_two_check_en   = st.chk_ctl[mfp_pkg::B_Q0 - 2];
    quarter_three_check_en = st.chk_ctl[mfp_pkg::B_Q0 - 3];
    fetch_correction_en    = st.chk_ctl[mfp_pkg::B_EEI];
    operand_correction_en  = st.chk_ctl[mfp_pkg::B_EED];
    parity_check_en        = st.chk_ctl[mfp_pkg::B_EPR];
    cache_miss_wait_en     = st.chk_ctl[mfp_pkg::B_SPD];
    protect_pin_mode       = st.chk_ctl[mfp_pkg::B_WPT];
    unused_block_one_en    = st.chk_ctl[mfp_pkg::B_EB1];
    unused_block_two_en    = st.chk_ctl[mfp_pkg::B_EB2];
    illegal_io_check_en    = st.chk_ctl[mfp_pkg::B_EIO];
    global_protect_flag    = st.chk_ctl[mfp_pkg::B_GPT];
    dma_split_bus_sel      = st.chk_ctl[mfp_pkg::B_DMX];
    dma_address_kind       = st.chk_ctl[mfp_pkg::B_DLP];
    ready_wait_bit_lo      = st.bus_ctl[mfp_pkg::B_WALO];
    ready_wait_bit_hi      = st.bus_ctl[mfp_pkg::B_WAHI];
    spare_io_check_en      = st.bus_ctl[mfp_pkg::B_SPI];
    checkbit_gen_select    = st.bus_ctl[mfp_pkg::B_PEG];
    bus_turnaround_idle_en = st.bus_ctl[mfp_pkg::B_IDL];
  end

  // Address path and check selection
  // Page lines only carry the DMA address in physical split mode
  always_comb
  begin
    quarter_en  = {quarter_three_check_en, quarter_two_check_en,
                   quarter_one_check_en, quarter_zero_check_en};
    phys_dma    = i_dma_ack && dma_split_bus_sel && !dma_address_kind;
    acc_page    = phys_dma ? i_page_select_lines : i_acc_addr[19:12];
    quarter_hit = quarter_en[i_acc_addr[19:18]];
    edac_hit    = quarter_hit && (i_acc_fetch ? fetch_correction_en
                                              : operand_correction_en);
    io_is_input = i_io_cmd[15];
    io_bad      = illegal_io_check_en && (
                    past_limit(i_io_cmd, io_is_input ? st.in_lim
                                                     : st.out_lim)
                    || (i_io_cmd[14:12] == mfp_pkg::IO_RSV_TAG)
                    || (spare_io_check_en
                        && (i_io_cmd[14:12] == mfp_pkg::IO_SPARE_TAG)));
    rd_flt_dat  = i_reg_rd && (i_reg_addr == mfp_pkg::ADR_FLT_DAT);
    capture     = i_acc_valid && i_mem_error && (!st.flt_held || rd_flt_dat);
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    next_st = st;

    // Register writes; fault registers are read-only
    if (i_reg_wr)
    begin
      unique case (i_reg_addr)
        mfp_pkg::ADR_CHK_CTL: next_st.chk_ctl = i_reg_wdata;
        mfp_pkg::ADR_BUS_CTL: next_st.bus_ctl = i_reg_wdata;
        mfp_pkg::ADR_BLK_ONE: next_st.blk_one = i_reg_wdata;
        mfp_pkg::ADR_BLK_TWO: next_st.blk_two = i_reg_wdata;
        mfp_pkg::ADR_OUT_LIM: next_st.out_lim =
          {6'h00, i_reg_wdata[mfp_pkg::LIM_HI:0]};
        mfp_pkg::ADR_IN_LIM:  next_st.in_lim =
          {6'h00, i_reg_wdata[mfp_pkg::LIM_HI:0]};
        default: ;
      endcase
    end

    // Command 4003 drops global protect, even over a write
    if (i_io_valid && (i_io_cmd == mfp_pkg::IO_GPT_CLR))
    begin
      next_st.chk_ctl[mfp_pkg::B_GPT] = 1'b0;
    end

    // Read data stands only in the cycle after the strobe
    next_st.rdata = 16'h0000;
    if (i_reg_rd)
    begin
      unique case (i_reg_addr)
        mfp_pkg::ADR_CHK_CTL: next_st.rdata = st.chk_ctl;
        mfp_pkg::ADR_BUS_CTL: next_st.rdata = st.bus_ctl;
        mfp_pkg::ADR_BLK_ONE: next_st.rdata = st.blk_one;
        mfp_pkg::ADR_BLK_TWO: next_st.rdata = st.blk_two;
        mfp_pkg::ADR_OUT_LIM: next_st.rdata = st.out_lim;
        mfp_pkg::ADR_IN_LIM:  next_st.rdata = st.in_lim;
        mfp_pkg::ADR_FLT_ADR: next_st.rdata = st.flt_adr;
        mfp_pkg::ADR_FLT_DAT: next_st.rdata = st.flt_dat;
        default:              ;
      endcase
    end

    // First fault capture; a new fault beats the rearm
    if (capture)
    begin
      next_st.flt_adr  = {acc_page[3:0], i_acc_addr[11:0]};
      next_st.flt_dat  = i_error_bits;
      next_st.flt_held = 1'b1;
    end
    else if (rd_flt_dat)
    begin
      next_st.flt_held = 1'b0;
    end

    // Per-access check mode, held until the next access
    if (i_acc_valid)
    begin
      next_st.edac_en    = edac_hit;
      next_st.parity_en  = quarter_hit && parity_check_en && !edac_hit;
      next_st.unused_mem =
        in_block(st.blk_one, unused_block_one_en, acc_page)
        || in_block(st.blk_two, unused_block_two_en, acc_page);
    end

    // Illegal command flag per I/O command
    if (i_io_valid)
    begin
      next_st.illegal_io = io_bad;
    end

    // Protect pin: strobe-shaped or steady level
    if (protect_pin_mode)
    begin
      next_st.wp_pin = i_prot_violation && i_acc_valid && i_acc_write;
    end
    else
    begin
      next_st.wp_pin = i_prot_violation;
    end

    // One wait state after a cache miss
    next_st.ext_ready = !(cache_miss_wait_en && i_cache_miss);

    // Idle clock ahead of grant on read requests
    next_st.req_seen  = i_bus_req;
    next_st.bus_grant = i_bus_req && (!(bus_turnaround_idle_en && i_bus_read)
                                      || st.req_seen);

    // Programmed wait states on the first ready source
    next_st.ready_a = 1'b0;
    unique case (st.rdy_state)
      mfp_pkg::RDY_IDLE:
      begin
        if (i_ready_a_start)
        begin
          if ({ready_wait_bit_hi, ready_wait_bit_lo} == 2'h0)
          begin
            next_st.ready_a = 1'b1;
          end
          else
          begin
            next_st.wait_cnt  = {ready_wait_bit_hi, ready_wait_bit_lo};
            next_st.rdy_state = mfp_pkg::RDY_WAIT;
          end
        end
      end
      mfp_pkg::RDY_WAIT:
      begin
        next_st.wait_cnt = st.wait_cnt - 2'h1;
        if (st.wait_cnt == 2'h1)
        begin
          next_st.ready_a   = 1'b1;
          next_st.rdy_state = mfp_pkg::RDY_IDLE;
        end
      end
    endcase

    // Page lines: driven except when they carry the DMA address
    next_st.page_out = i_cpu_page;
    next_st.page_oe  = !phys_dma;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Reset loads the defaults, global protect set among them
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      st <= mfp_pkg::ST_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // All straight from flip-flops
  always_comb
  begin
    o_reg_rdata              = st.rdata;
    o_edac_en                = st.edac_en;
    o_parity_en              = st.parity_en;
    o_parity_odd             = st.chk_ctl[mfp_pkg::B_ODD];
    o_checkbit_gen_select    = checkbit_gen_select;
    o_unused_mem             = st.unused_mem;
    o_write_protect_pin      = st.wp_pin;
    o_global_protect_flag    = global_protect_flag;
    o_illegal_io             = st.illegal_io;
    o_page_select_lines      = st.page_out;
    o_page_select_oe         = st.page_oe;
    o_dma_split_bus_sel      = dma_split_bus_sel;
    o_dma_address_kind       = dma_address_kind;
    o_ext_ready              = st.ext_ready;
    o_first_ready_source     = st.ready_a;
    o_bus_grant              = st.bus_grant;
    o_bus_turnaround_idle_en = bus_turnaround_idle_en;
  end

endmodule

/* File: mfp_asserts.sv */
`timescale 1ns/100ps
// ----------------------------------------
// Port-level checker
// ----------------------------------------
module mfp_asserts
(
  // Clock, reset and register port
  input wire logic        i_sys_clk,
  input wire logic        i_rst_b,
  input wire logic [15:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [15:0] o_reg_rdata,
  // Access side
  input wire logic        i_acc_valid,
  input wire logic [19:0] i_acc_addr,
  input wire logic        i_acc_fetch,
  input wire logic        i_acc_write,
  input wire logic        i_prot_violation,
  input wire logic        o_edac_en,
  input wire logic        o_parity_en,
  input wire logic        o_write_protect_pin,
  input wire logic        o_global_protect_flag,
  input wire logic        i_io_valid,
  input wire logic [15:0] i_io_cmd,
  // DMA, ready and grant
  input wire logic        i_dma_ack,
  input wire logic        o_page_select_oe,
  input wire logic        i_cache_miss,
  input wire logic        i_ready_a_start,
  input wire logic        i_bus_req,
  input wire logic        i_bus_read,
  input wire logic        o_ext_ready,
  input wire logic        o_first_ready_source,
  input wire logic        o_bus_grant
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  logic [15:0] chk;
  logic [15:0] bus;
  logic        corr;
  logic        exp_edac;
  logic        exp_par;
  logic        exp_wp;

  // Shadow control words
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      chk <= mfp_pkg::RST_CHK_CTL;
      bus <= mfp_pkg::RST_BUS_CTL;
    end
    else if (i_reg_wr && i_reg_addr == mfp_pkg::ADR_CHK_CTL)
      chk <= i_reg_wdata;
    else if (i_reg_wr && i_reg_addr == mfp_pkg::ADR_BUS_CTL)
      bus <= i_reg_wdata;
  end

  // Expected verdicts
  always_comb
  begin
    corr     = i_acc_fetch ? chk[10] : chk[9];
    exp_edac = chk[4'd15 - {2'b00, i_acc_addr[19:18]}] & corr;
    exp_par  = chk[4'd15 - {2'b00, i_acc_addr[19:18]}] & chk[8] & ~corr;
    exp_wp   = chk[6] ? (i_prot_violation & i_acc_valid & i_acc_write) : i_prot_violation;
  end

  a_rdata_idle: assert property (!i_reg_rd |=> o_reg_rdata == 16'h0000)
    else $error("stray read data");
  a_edac_class: assert property (i_acc_valid |=> o_edac_en == $past(exp_edac))
    else $error("edac enable wrong");
  a_parity_class: assert property (i_acc_valid |=> o_parity_en == $past(exp_par))
    else $error("parity enable wrong");
  a_miss_wait: assert property (i_cache_miss && chk[7] |=> !o_ext_ready ##1 o_ext_ready)
    else $error("miss wait wrong");
  a_grant_fast: assert property ($rose(i_bus_req) && !(i_bus_read && bus[10])
    |=> o_bus_grant)
    else $error("grant late");
  a_grant_idle: assert property ($rose(i_bus_req) && i_bus_read && bus[10]
    |=> !o_bus_grant ##1 o_bus_grant)
    else $error("idle cycle missing");
  a_page_float: assert property (i_dma_ack && chk[1] && !chk[0] |=> !o_page_select_oe)
    else $error("page lines driven");
  a_gpt_clear: assert property (i_io_valid && i_io_cmd == mfp_pkg::IO_GPT_CLR
    |=> !o_global_protect_flag)
    else $error("protect not cleared");
  a_wp_pin: assert property (o_write_protect_pin == $past(exp_wp))
    else $error("protect pin wrong");
  a_first_ready_source_zero: assert property (i_ready_a_start && bus[15:14] == 2'b00
    |=> o_first_ready_source)
    else $error("ready pulse late");

  // Main scenarios reached
  c_edac: cover property (i_acc_valid && exp_edac);
  c_miss: cover property (i_cache_miss && chk[7]);
  c_idle: cover property ($rose(i_bus_req) && i_bus_read && bus[10]);
endmodule

bind mfp_top mfp_asserts u_chk (.i_sys_clk, .i_rst_b, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
  .i_reg_rd, .o_reg_rdata, .i_acc_valid, .i_acc_addr, .i_acc_fetch, .i_acc_write,
  .i_prot_violation, .o_edac_en, .o_parity_en, .o_write_protect_pin, .o_global_protect_flag,
  .i_io_valid, .i_io_cmd, .i_dma_ack, .o_page_select_oe, .i_cache_miss, .i_ready_a_start,
  .i_bus_req, .i_bus_read, .o_ext_ready, .o_first_ready_source, .o_bus_grant);

/* File: mfp_cpu_model.sv */
`timescale 1ns/100ps
// ----------------------------------------
// Processor side access source
// ----------------------------------------
module mfp_cpu_model
(
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_b,
  // Request from the bench
  input  wire logic        i_go,
  input  wire logic [19:0] i_addr,
  input  wire logic        i_fetch,
  input  wire logic        i_write,
  input  wire logic        i_err,
  input  wire logic [15:0] i_bits,
  // Access lines toward the block
  output logic             o_acc_valid,
  output logic      [19:0] o_acc_addr,
  output logic             o_acc_fetch,
  output logic             o_acc_write,
  output logic             o_mem_error,
  output logic      [15:0] o_error_bits
);
  logic [39:0] q;

  // Qualifiers toggle between accesses so stale values never hold steady
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      q <= '0;
    else if (i_go)
      q <= {1'b1, i_addr, i_fetch, i_write, i_err, i_bits};
    else
      q <= {1'b0, ~q[38:0]};
  end
  // Access lines out of the one register
  assign {o_acc_valid, o_acc_addr, o_acc_fetch, o_acc_write, o_mem_error, o_error_bits} = q;
endmodule

/* File: tb_top.sv */
`timescale 1ns/100ps
`define CHK(nm, ex, gt) \
  begin \
    total_checks++; \
    if ((gt) !== (ex)) \
    begin \
      failures++; \
      $display("BAD %s expected %h seen %h", nm, ex, gt); \
    end \
  end
module tb_top;
  logic [15:0] i_reg_addr, i_reg_wdata, o_reg_rdata, i_error_bits, i_io_cmd, p_bits;
  logic [19:0] i_acc_addr, p_addr;
  logic [7:0]  i_cpu_page, i_page_select_lines, o_page_select_lines;
  logic        i_sys_clk, i_rst_b, i_reg_wr, i_reg_rd, i_acc_valid, i_acc_fetch, i_acc_write;
  logic        i_mem_error, i_prot_violation, i_io_valid, i_dma_ack, i_cache_miss;
  logic        i_ready_a_start, i_bus_req, i_bus_read, p_go, p_fetch, p_write, p_err;
  logic        o_edac_en, o_parity_en, o_parity_odd, o_checkbit_gen_select, o_unused_mem;
  logic        o_write_protect_pin, o_global_protect_flag, o_illegal_io, o_page_select_oe;
  logic        o_dma_split_bus_sel, o_dma_address_kind, o_ext_ready, o_first_ready_source;
  logic        o_bus_grant, o_bus_turnaround_idle_en;
  int          failures, total_checks, cycles;

  mfp_top dut (.i_sys_clk, .i_rst_b, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
    .o_reg_rdata, .i_acc_valid, .i_acc_addr, .i_acc_fetch, .i_acc_write, .i_mem_error,
    .i_error_bits, .i_prot_violation, .o_edac_en, .o_parity_en, .o_parity_odd,
    .o_checkbit_gen_select, .o_unused_mem, .o_write_protect_pin, .o_global_protect_flag,
    .i_io_valid, .i_io_cmd, .o_illegal_io, .i_dma_ack, .i_cpu_page, .i_page_select_lines,
    .o_page_select_lines, .o_page_select_oe, .o_dma_split_bus_sel, .o_dma_address_kind,
    .i_cache_miss, .i_ready_a_start, .i_bus_req, .i_bus_read, .o_ext_ready,
    .o_first_ready_source, .o_bus_grant, .o_bus_turnaround_idle_en);
  mfp_cpu_model u_cpu (.i_sys_clk, .i_rst_b, .i_go(p_go), .i_addr(p_addr), .i_fetch(p_fetch),
    .i_write(p_write), .i_err(p_err), .i_bits(p_bits), .o_acc_valid(i_acc_valid),
    .o_acc_addr(i_acc_addr), .o_acc_fetch(i_acc_fetch), .o_acc_write(i_acc_write),
    .o_mem_error(i_mem_error), .o_error_bits(i_error_bits));

  // ----------------------------------------
  // Clock, hang guard and verdict
  // ----------------------------------------
  initial
  begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  // Hang guard
  always @(posedge i_sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  task automatic wr(input logic [15:0] a, d);
    @(posedge i_sys_clk);
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    i_reg_wr    <= 1'b1;
    @(posedge i_sys_clk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic wchk(input logic [15:0] d);
    wr(mfp_pkg::ADR_CHK_CTL, d);
  endtask
  task automatic rchk(input logic [15:0] a, ex);
    @(posedge i_sys_clk);
    i_reg_addr <= a;
    i_reg_rd   <= 1'b1;
    @(posedge i_sys_clk);
    i_reg_rd <= 1'b0;
    #1 `CHK("reg read", ex, o_reg_rdata)
  endtask
  // Access via the model; ends just after the block took it
  task automatic acc(input logic [19:0] a, input logic f, w, e = 1'b0,
                     input logic [15:0] b = 16'h0000);
    @(posedge i_sys_clk);
    {p_go, p_addr, p_fetch, p_write, p_err, p_bits} <= {1'b1, a, f, w, e, b};
    @(posedge i_sys_clk);
    p_go <= 1'b0;
    @(posedge i_sys_clk);
    #1;
  endtask
  task automatic io(input logic [15:0] c);
    @(posedge i_sys_clk);
    i_io_valid <= 1'b1;
    i_io_cmd   <= c;
    @(posedge i_sys_clk);
    i_io_valid <= 1'b0;
    #1;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    `CHK("protect", 1'b1, o_global_protect_flag)
    rchk(mfp_pkg::ADR_CHK_CTL, mfp_pkg::RST_CHK_CTL);
    rchk(mfp_pkg::ADR_BUS_CTL, mfp_pkg::RST_BUS_CTL);
    wr(mfp_pkg::ADR_OUT_LIM, 16'hFFFF);
    rchk(mfp_pkg::ADR_OUT_LIM, 16'h03FF);
    wr(mfp_pkg::ADR_IN_LIM, 16'hFC2A);
    rchk(mfp_pkg::ADR_IN_LIM, 16'h002A);
    wr(mfp_pkg::ADR_BLK_TWO, 16'h30A0);
    rchk(mfp_pkg::ADR_BLK_TWO, 16'h30A0);
    wr(mfp_pkg::ADR_FLT_ADR, 16'h1234);
    rchk(mfp_pkg::ADR_FLT_ADR, 16'h0000);
    rchk(16'h1F5F, 16'h0000);
    $display("t_regs done");
  endtask
  task automatic t_check();
    wchk(16'h8400);
    acc(20'h00010, 1'b1, 1'b0);
    `CHK("edac fetch", 2'b10, {o_edac_en, o_parity_en})
    acc(20'h00010, 1'b0, 1'b0);
    `CHK("edac operand", 2'b00, {o_edac_en, o_parity_en})
    acc(20'h40010, 1'b1, 1'b0);
    `CHK("quarter off", 2'b00, {o_edac_en, o_parity_en})
    wchk(16'h2B01);
    acc(20'h80000, 1'b0, 1'b0);
    `CHK("edac wins", 2'b10, {o_edac_en, o_parity_en})
    acc(20'hBFFFF, 1'b1, 1'b0);
    `CHK("parity", 2'b01, {o_edac_en, o_parity_en})
    `CHK("odd", 1'b1, o_parity_odd)
    `CHK("dma kind", 2'b01, {o_dma_split_bus_sel, o_dma_address_kind})
    wr(mfp_pkg::ADR_BUS_CTL, 16'h0800);
    #1 `CHK("gen select", 2'b10, {o_checkbit_gen_select, o_bus_turnaround_idle_en})
    $display("t_check done");
  endtask
  task automatic t_unused();
    logic [7:0] pg [4] = '{8'h0F, 8'h10, 8'h20, 8'h21};
    logic       ex [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    wr(mfp_pkg::ADR_BLK_ONE, 16'h1020);
    wchk(16'h0020);
    for (int i = 0; i < 4; i++)
    begin
      acc({pg[i], 12'h000}, 1'b0, 1'b0);
      `CHK("unused", ex[i], o_unused_mem)
    end
    {i_dma_ack, i_page_select_lines} <= {1'b1, 8'h15};
    wchk(16'h0022);
    acc(20'h00000, 1'b0, 1'b0);
    `CHK("page in", 1'b1, o_unused_mem)
    i_dma_ack <= 1'b0;
    wchk(16'h0000);
    acc(20'h10000, 1'b0, 1'b0);
    `CHK("block off", 1'b0, o_unused_mem)
    $display("t_unused done");
  endtask
  task automatic t_fault();
    acc(20'h5A123, 1'b0, 1'b0, 1'b1, 16'h0040);
    acc(20'h12345, 1'b0, 1'b0, 1'b1, 16'h8000);
    rchk(mfp_pkg::ADR_FLT_ADR, 16'hA123);
    rchk(mfp_pkg::ADR_FLT_DAT, 16'h0040);
    acc(20'h12345, 1'b0, 1'b0, 1'b1, 16'h8000);
    rchk(mfp_pkg::ADR_FLT_ADR, 16'h2345);
    $display("t_fault done");
  endtask
  task automatic t_io();
    logic [15:0] cmd [6] = '{16'h0005, 16'h0004, 16'h802A, 16'h8029, 16'h7000, 16'h6000};
    logic        ex  [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    wr(mfp_pkg::ADR_OUT_LIM, 16'h0005);
    wchk(16'h000C);
    for (int i = 0; i < 6; i++)
    begin
      io(cmd[i]);
      `CHK("pio", ex[i], o_illegal_io)
    end
    wr(mfp_pkg::ADR_BUS_CTL, 16'h2000);
    io(16'h6000);
    `CHK("spare pio", 1'b1, o_illegal_io)
    io(mfp_pkg::IO_GPT_CLR);
    `CHK("protect clear", 1'b0, o_global_protect_flag)
    $display("t_io done");
  endtask
  task automatic t_misc();
    wchk(16'h00C2);
    @(posedge i_sys_clk);
    i_cache_miss <= 1'b1;
    @(posedge i_sys_clk);
    i_cache_miss <= 1'b0;
    #1 `CHK("miss wait", 1'b0, o_ext_ready)
    i_prot_violation <= 1'b1;
    acc(20'h00000, 1'b0, 1'b1);
    `CHK("protect pulse", 1'b1, o_write_protect_pin)
    @(posedge i_sys_clk);
    #1 `CHK("pulse ends", 1'b0, o_write_protect_pin)
    wchk(16'h0082);
    @(posedge i_sys_clk);
    #1 `CHK("protect level", 1'b1, o_write_protect_pin)
    i_prot_violation <= 1'b0;
    i_dma_ack        <= 1'b1;
    @(posedge i_sys_clk);
    #1 `CHK("page float", 9'h05A, {o_page_select_oe, o_page_select_lines})
    i_dma_ack <= 1'b0;
    wr(mfp_pkg::ADR_BUS_CTL, 16'h4400);
    @(posedge i_sys_clk);
    i_ready_a_start <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      @(posedge i_sys_clk);
      i_ready_a_start <= 1'b0;
      #1 `CHK("ready wait", i == 2, o_first_ready_source)
    end
    i_bus_req  <= 1'b1;
    i_bus_read <= 1'b1;
    @(posedge i_sys_clk);
    #1 `CHK("idle grant", 1'b0, o_bus_grant)
    @(posedge i_sys_clk);
    #1 `CHK("idle grant", 1'b1, o_bus_grant)
    i_bus_req <= 1'b0;
    @(posedge i_sys_clk);
    #1 `CHK("grant drop", 1'b0, o_bus_grant)
    $display("t_misc done");
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {i_rst_b, i_reg_wr, i_reg_rd, i_io_valid, i_dma_ack, i_cache_miss} = '0;
    {i_prot_violation, i_ready_a_start, i_bus_req, i_bus_read, p_go} = '0;
    {p_fetch, p_write, p_err, p_addr, p_bits, i_reg_addr, i_reg_wdata, i_io_cmd} = '0;
    i_cpu_page          = 8'h5A;
    i_page_select_lines = 8'h00;
    {failures, total_checks, cycles} = '0;
    repeat (2) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    t_regs();
    t_check();
    t_unused();
    t_fault();
    t_io();
    t_misc();
    close_out();
  end
endmodule
